/* rtl/tlvic_top.sv */
// Two-level vectored interrupt controller: registers, acceptance sequence, status
`timescale 1ns/100ps
`default_nettype none

module tlvic_top (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Request flags from the peripherals
  input  wire logic        supply_monitor_irq_request_i,
  input  wire logic        watchdog_irq_request_i,
  input  wire logic        pin_irq0_request_i,
  input  wire logic        converter_irq_request_i,
  input  wire logic        timer0_irq_request_i,
  input  wire logic        pin_irq1_request_i,
  input  wire logic        timer1_irq_request_i,
  input  wire logic        serial_sync_irq_request_i,
  input  wire logic        uart_rxtx_irq_request_i,
  input  wire logic        timer2_irq_request_i,
  input  wire logic        interval_counter_irq_request_i,
  // Core handshake
  input  wire logic        core_ack_i,
  input  wire logic        core_reti_i,
  output logic             core_irq_req_o,
  output logic      [15:0] core_vector_o,
  output logic             core_push_pc_o,
  output logic             core_load_pc_o,
  output logic      [10:0] src_taken_o,
  // Event interrupt
  output logic             irq_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    tlvic_pkg::tlvic_fsm_e state;
    logic [7:0]            ien_pri;
    logic [7:0]            ien_sec;
    logic [7:0]            ipr_pri;
    logic                  act_hi;
    logic                  act_lo;
    logic [3:0]            src;
    logic                  high;
    logic [15:0]           vector;
    logic                  req;
    logic                  push;
    logic                  load;
    logic [10:0]           taken;
    logic [7:0]            rdata;
    logic [3:0]            stat;
    logic [3:0]            mask;
    logic                  irq;
  } tlvic_regs_s;

  tlvic_regs_s q;
  tlvic_regs_s d;

  logic [10:0] req_c;
  logic [10:0] en_c;
  logic [10:0] prio_c;
  logic [10:0] pend_c;
  logic        found_c;
  logic [3:0]  win_src_c;
  logic        win_high_c;
  logic [3:0]  ev_c;
  logic [3:0]  clr_c;

  // ==========================================================================
  // Source map in polling order
  always_comb begin
    req_c[tlvic_pkg::SRC_SUPPLY] = supply_monitor_irq_request_i;
    req_c[tlvic_pkg::SRC_WDOG]   = watchdog_irq_request_i;
    req_c[tlvic_pkg::SRC_PIN0]   = pin_irq0_request_i;
    req_c[tlvic_pkg::SRC_CONV]   = converter_irq_request_i;
    req_c[tlvic_pkg::SRC_T0]     = timer0_irq_request_i;
    req_c[tlvic_pkg::SRC_PIN1]   = pin_irq1_request_i;
    req_c[tlvic_pkg::SRC_T1]     = timer1_irq_request_i;
    req_c[tlvic_pkg::SRC_SERIAL] = serial_sync_irq_request_i;
    req_c[tlvic_pkg::SRC_UART]   = uart_rxtx_irq_request_i;
    req_c[tlvic_pkg::SRC_T2]     = timer2_irq_request_i;
    req_c[tlvic_pkg::SRC_INTV]   = interval_counter_irq_request_i;

    // Watchdog has no enable bit of its own, only the global gate
    en_c[tlvic_pkg::SRC_WDOG]   = 1'b1;
    en_c[tlvic_pkg::SRC_PIN0]   = q.ien_pri[tlvic_pkg::PIN0_BIT];
    en_c[tlvic_pkg::SRC_CONV]   = q.ien_pri[tlvic_pkg::CONV_BIT];
    en_c[tlvic_pkg::SRC_T0]     = q.ien_pri[tlvic_pkg::T0_BIT];
    en_c[tlvic_pkg::SRC_PIN1]   = q.ien_pri[tlvic_pkg::PIN1_BIT];
    en_c[tlvic_pkg::SRC_T1]     = q.ien_pri[tlvic_pkg::T1_BIT];
    en_c[tlvic_pkg::SRC_UART]   = q.ien_pri[tlvic_pkg::UART_BIT];
    en_c[tlvic_pkg::SRC_T2]     = q.ien_pri[tlvic_pkg::T2_BIT];
    en_c[tlvic_pkg::SRC_SUPPLY] = q.ien_sec[tlvic_pkg::SEC_EN_SUPPLY_BIT];
    en_c[tlvic_pkg::SRC_SERIAL] = q.ien_sec[tlvic_pkg::SEC_EN_SERIAL_BIT];
    en_c[tlvic_pkg::SRC_INTV]   = q.ien_sec[tlvic_pkg::SEC_EN_INTV_BIT];

    prio_c[tlvic_pkg::SRC_WDOG]   = tlvic_pkg::WDOG_PRIO_HIGH;
    prio_c[tlvic_pkg::SRC_PIN0]   = q.ipr_pri[tlvic_pkg::PIN0_BIT];
    prio_c[tlvic_pkg::SRC_CONV]   = q.ipr_pri[tlvic_pkg::CONV_BIT];
    prio_c[tlvic_pkg::SRC_T0]     = q.ipr_pri[tlvic_pkg::T0_BIT];
    prio_c[tlvic_pkg::SRC_PIN1]   = q.ipr_pri[tlvic_pkg::PIN1_BIT];
    prio_c[tlvic_pkg::SRC_T1]     = q.ipr_pri[tlvic_pkg::T1_BIT];
    prio_c[tlvic_pkg::SRC_UART]   = q.ipr_pri[tlvic_pkg::UART_BIT];
    prio_c[tlvic_pkg::SRC_T2]     = q.ipr_pri[tlvic_pkg::T2_BIT];
    prio_c[tlvic_pkg::SRC_SUPPLY] = q.ien_sec[tlvic_pkg::SEC_PRI_SUPPLY_BIT];
    prio_c[tlvic_pkg::SRC_SERIAL] = q.ien_sec[tlvic_pkg::SEC_PRI_SERIAL_BIT];
    prio_c[tlvic_pkg::SRC_INTV]   = q.ien_sec[tlvic_pkg::SEC_PRI_INTV_BIT];

    pend_c = req_c & en_c & {11{q.ien_pri[tlvic_pkg::GLOBAL_BIT]}};
  end

  tlvic_prio u_prio (
    .pend_i   (pend_c),
    .prio_i   (prio_c),
    .act_hi_i (q.act_hi),
    .act_lo_i (q.act_lo),
    .found_o  (found_c),
    .src_o    (win_src_c),
    .high_o   (win_high_c)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    d       = q;
    d.push  = 1'b0;
    d.load  = 1'b0;
    d.taken = 11'h000;
    d.rdata = 8'h00;
    ev_c    = 4'h0;
    clr_c   = 4'h0;

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        tlvic_pkg::ADDR_IEN_PRI: d.ien_pri = reg_wdata_i;
        // Unimplemented top bits hold their reset level
        tlvic_pkg::ADDR_IEN_SEC: d.ien_sec = {1'b1, reg_wdata_i[6:0]};
        tlvic_pkg::ADDR_IPR_PRI: d.ipr_pri = {1'b0, reg_wdata_i[6:0]};
        tlvic_pkg::ADDR_MASK:    d.mask    = reg_wdata_i[3:0];
        default: ;
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        tlvic_pkg::ADDR_IEN_PRI: d.rdata = q.ien_pri;
        tlvic_pkg::ADDR_IEN_SEC: d.rdata = q.ien_sec;
        tlvic_pkg::ADDR_IPR_PRI: d.rdata = q.ipr_pri;
        tlvic_pkg::ADDR_MASK:    d.rdata = {4'h0, q.mask};
        tlvic_pkg::ADDR_LEVEL:   d.rdata = {q.act_hi, q.act_lo, q.state, q.src};
        tlvic_pkg::ADDR_STATUS: begin
          d.rdata = {4'h0, q.stat};
          clr_c   = q.stat;
        end
        default: d.rdata = 8'h00;
      endcase
    end

    // Innermost level ends first
    if (core_reti_i) begin
      if (q.act_hi) begin
        d.act_hi = 1'b0;
      end else if (q.act_lo) begin
        d.act_lo = 1'b0;
      end else begin
        ev_c[tlvic_pkg::EV_RETI_IDLE] = 1'b1;
      end
    end

    unique case (q.state)
      tlvic_pkg::ST_IDLE: begin
        if (found_c) begin
          d.state  = tlvic_pkg::ST_REQ;
          d.req    = 1'b1;
          d.src    = win_src_c;
          d.high   = win_high_c;
          d.vector = tlvic_pkg::vector_of(win_src_c);
        end
      end
      tlvic_pkg::ST_REQ: begin
        // The core acknowledges what it saw, so the presented source is taken
        if (core_ack_i) begin
          d.state             = tlvic_pkg::ST_PUSH;
          d.req               = 1'b0;
          d.push              = 1'b1;
          d.taken             = 11'h001 << q.src;
          if (q.high) begin
            d.act_hi                   = 1'b1;
            ev_c[tlvic_pkg::EV_ACC_HI] = 1'b1;
            ev_c[tlvic_pkg::EV_PREEMPT] = q.act_lo;
          end else begin
            d.act_lo                   = 1'b1;
            ev_c[tlvic_pkg::EV_ACC_LO] = 1'b1;
          end
        end else if (!found_c) begin
          d.state = tlvic_pkg::ST_IDLE;
          d.req   = 1'b0;
        end else begin
          d.src    = win_src_c;
          d.high   = win_high_c;
          d.vector = tlvic_pkg::vector_of(win_src_c);
        end
      end
      tlvic_pkg::ST_PUSH: begin
        d.state = tlvic_pkg::ST_LOAD;
        d.load  = 1'b1;
      end
      tlvic_pkg::ST_LOAD: begin
        d.state = tlvic_pkg::ST_IDLE;
      end
    endcase

    // An event in the clearing read's cycle survives it
    d.stat = (q.stat & ~clr_c) | ev_c;
    d.irq  = |(d.stat & d.mask);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q         <= '0;
      q.state   <= tlvic_pkg::ST_IDLE;
      q.ien_pri <= tlvic_pkg::RST_IEN_PRI;
      q.ien_sec <= tlvic_pkg::RST_IEN_SEC;
      q.ipr_pri <= tlvic_pkg::RST_IPR_PRI;
      q.stat    <= tlvic_pkg::RST_STATUS;
      q.mask    <= tlvic_pkg::RST_MASK;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o    = q.rdata;
  assign core_irq_req_o = q.req;
  assign core_vector_o  = q.vector;
  assign core_push_pc_o = q.push;
  assign core_load_pc_o = q.load;
  assign src_taken_o    = q.taken;
  assign irq_o          = q.irq;

  // ==========================================================================
  // Checks
  property p_global_gate;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_IDLE && !q.ien_pri[tlvic_pkg::GLOBAL_BIT]) |=> !core_irq_req_o;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request with global gate off");

  property p_gated_request;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(core_irq_req_o) |-> $past(pend_c[win_src_c]);
  endproperty
  a_gated_request: assert property (p_gated_request) else $error("request from gated source");

  property p_level_bit;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(core_irq_req_o) |-> (q.high == $past(prio_c[win_src_c]));
  endproperty
  a_level_bit: assert property (p_level_bit) else $error("presented level mismatch");

  property p_preempt;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_IDLE && q.act_lo && !q.act_hi && |(pend_c & prio_c))
      |=> (core_irq_req_o && q.high);
  endproperty
  a_preempt: assert property (p_preempt) else $error("high request did not preempt");

  property p_high_first;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_IDLE && !q.act_hi && !q.act_lo
      && |(pend_c & prio_c) && |(pend_c & ~prio_c)) |=> q.high;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served before high");

  property p_no_same_level;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_IDLE && q.act_hi) |=> !core_irq_req_o;
  endproperty
  a_no_same_level: assert property (p_no_same_level) else $error("same level preempted");

  property p_poll_first;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_IDLE && !q.act_hi && !q.act_lo
      && pend_c[tlvic_pkg::SRC_SUPPLY]
      && (prio_c[tlvic_pkg::SRC_SUPPLY] || !(|(pend_c & prio_c))))
      |=> (q.src == tlvic_pkg::SRC_SUPPLY);
  endproperty
  a_poll_first: assert property (p_poll_first) else $error("polling order broken");

  property p_push_load;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (q.state == tlvic_pkg::ST_REQ && core_ack_i)
      |=> core_push_pc_o ##1 (core_load_pc_o && $stable(core_vector_o));
  endproperty
  a_push_load: assert property (p_push_load) else $error("push then load missing");

  property p_vector;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    core_irq_req_o |-> (core_vector_o == tlvic_pkg::vector_of(q.src));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector address");

  property p_reti_ends;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (core_reti_i && q.act_hi && q.state != tlvic_pkg::ST_REQ) |=> !q.act_hi;
  endproperty
  a_reti_ends: assert property (p_reti_ends) else $error("return left level active");

endmodule

`default_nettype wire

/* rtl/tlvic_pkg.sv */
// Constants, types and vector table of the two-level vectored interrupt controller
package tlvic_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NSRC   = 11;
  localparam int unsigned NEVENT = 4;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_IEN_PRI = 8'ha8;
  localparam logic [7:0] ADDR_IEN_SEC = 8'ha9;
  localparam logic [7:0] ADDR_IPR_PRI = 8'hb8;
  localparam logic [7:0] ADDR_STATUS  = 8'hc8;
  localparam logic [7:0] ADDR_MASK    = 8'hc9;
  localparam logic [7:0] ADDR_LEVEL   = 8'hca;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_IEN_PRI = 8'h00;
  localparam logic [7:0] RST_IEN_SEC = 8'ha0;
  localparam logic [7:0] RST_IPR_PRI = 8'h00;
  localparam logic [3:0] RST_STATUS  = 4'h0;
  localparam logic [3:0] RST_MASK    = 4'h0;

  // ==========================================================================
  // Field positions, primary enable and primary priority share them
  localparam int unsigned GLOBAL_BIT = 7;
  localparam int unsigned CONV_BIT   = 6;
  localparam int unsigned T2_BIT     = 5;
  localparam int unsigned UART_BIT   = 4;
  localparam int unsigned T1_BIT     = 3;
  localparam int unsigned PIN1_BIT   = 2;
  localparam int unsigned T0_BIT     = 1;
  localparam int unsigned PIN0_BIT   = 0;
  localparam int unsigned SEC_PRI_INTV_BIT   = 6;
  localparam int unsigned SEC_PRI_SUPPLY_BIT = 5;
  localparam int unsigned SEC_PRI_SERIAL_BIT = 4;
  localparam int unsigned SEC_ZERO_BIT       = 3;
  localparam int unsigned SEC_EN_INTV_BIT    = 2;
  localparam int unsigned SEC_EN_SUPPLY_BIT  = 1;
  localparam int unsigned SEC_EN_SERIAL_BIT  = 0;
  localparam logic        WDOG_PRIO_HIGH     = 1'b1;

  // ==========================================================================
  // Source indices in polling order, 0 polled first
  localparam logic [3:0] SRC_SUPPLY = 4'h0;
  localparam logic [3:0] SRC_WDOG   = 4'h1;
  localparam logic [3:0] SRC_PIN0   = 4'h2;
  localparam logic [3:0] SRC_CONV   = 4'h3;
  localparam logic [3:0] SRC_T0     = 4'h4;
  localparam logic [3:0] SRC_PIN1   = 4'h5;
  localparam logic [3:0] SRC_T1     = 4'h6;
  localparam logic [3:0] SRC_SERIAL = 4'h7;
  localparam logic [3:0] SRC_UART   = 4'h8;
  localparam logic [3:0] SRC_T2     = 4'h9;
  localparam logic [3:0] SRC_INTV   = 4'ha;

  // ==========================================================================
  // Event bits of the status and mask registers
  localparam int unsigned EV_ACC_LO    = 0;
  localparam int unsigned EV_ACC_HI    = 1;
  localparam int unsigned EV_PREEMPT   = 2;
  localparam int unsigned EV_RETI_IDLE = 3;

  // ==========================================================================
  // Vector addresses
  localparam logic [15:0] VEC_PIN0   = 16'h0003;
  localparam logic [15:0] VEC_T0     = 16'h000b;
  localparam logic [15:0] VEC_PIN1   = 16'h0013;
  localparam logic [15:0] VEC_T1     = 16'h001b;
  localparam logic [15:0] VEC_UART   = 16'h0023;
  localparam logic [15:0] VEC_T2     = 16'h002b;
  localparam logic [15:0] VEC_CONV   = 16'h0033;
  localparam logic [15:0] VEC_SERIAL = 16'h003b;
  localparam logic [15:0] VEC_SUPPLY = 16'h0043;
  localparam logic [15:0] VEC_INTV   = 16'h0053;
  localparam logic [15:0] VEC_WDOG   = 16'h005b;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_PUSH, ST_LOAD} tlvic_fsm_e;

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    logic [15:0] v;
    v = 16'h0000;
    unique case (src)
      SRC_SUPPLY: v = VEC_SUPPLY;
      SRC_WDOG:   v = VEC_WDOG;
      SRC_PIN0:   v = VEC_PIN0;
      SRC_CONV:   v = VEC_CONV;
      SRC_T0:     v = VEC_T0;
      SRC_PIN1:   v = VEC_PIN1;
      SRC_T1:     v = VEC_T1;
      SRC_SERIAL: v = VEC_SERIAL;
      SRC_UART:   v = VEC_UART;
      SRC_T2:     v = VEC_T2;
      SRC_INTV:   v = VEC_INTV;
      default:    v = 16'h0000;
    endcase
    return v;
  endfunction

endpackage

/* rtl/tlvic_prio.sv */
// Two-level priority resolver with fixed polling order
`timescale 1ns/100ps
`default_nettype none

module tlvic_prio (
  // Gated requests and their levels, index 0 polled first
  input  wire logic [10:0] pend_i,
  input  wire logic [10:0] prio_i,
  // Levels currently in service
  input  wire logic        act_hi_i,
  input  wire logic        act_lo_i,
  // Winner
  output logic             found_o,
  output logic [3:0]       src_o,
  output logic             high_o
);

  logic [10:0] hi_c;
  logic [10:0] lo_c;

  always_comb begin
    hi_c    = pend_i & prio_i;
    lo_c    = pend_i & ~prio_i;
    found_o = 1'b0;
    src_o   = 4'h0;
    high_o  = 1'b0;
    // High beats low, and may cut into a low routine
    if ((hi_c != 11'h000) && !act_hi_i) begin
      found_o = 1'b1;
      high_o  = 1'b1;
      for (int i = 10; i >= 0; i--) begin
        if (hi_c[i]) begin
          src_o = 4'(i);
        end
      end
    end else if ((lo_c != 11'h000) && !act_hi_i && !act_lo_i) begin
      found_o = 1'b1;
      for (int i = 10; i >= 0; i--) begin
        if (lo_c[i]) begin
          src_o = 4'(i);
        end
      end
    end
  end

endmodule

`default_nettype wire

/* tb/tlvic_core_model.sv */
// Behavioural core model: acknowledges requests and reports served vectors
`timescale 1ns/100ps
`default_nettype none

module tlvic_core_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Controller side
  input  wire logic        irq_req_i,
  input  wire logic [15:0] vector_i,
  input  wire logic        load_i,
  input  wire logic [1:0]  ack_dly_i,
  output logic             ack_o,
  // Observation
  output logic             served_o,
  output logic      [15:0] served_vec_o
);
  logic [1:0] cnt_q;

  // ==========================================================================
  // Acknowledge after a chosen wait, fetch vector on the load pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o        <= 1'b0;
      cnt_q        <= 2'h0;
      served_o     <= 1'b0;
      served_vec_o <= 16'h0000;
    end else begin
      served_o <= load_i;
      if (load_i) begin
        served_vec_o <= vector_i;
      end
      // Ack is a single pulse; request drops the cycle after it is taken
      if (irq_req_i && !ack_o) begin
        if (cnt_q == ack_dly_i) begin
          ack_o <= 1'b1;
          cnt_q <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end else begin
        ack_o <= 1'b0;
        cnt_q <= 2'h0;
      end
    end
  end
endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench of the two-level vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        clk_sys_i, reset_n_i, reg_wr, reg_rd, core_reti, rd_d, push_d;
  logic        req, ack, push, load, irq, served;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [10:0] flags, set_m, clr_m, taken, exp_taken;
  logic [15:0] vec, served_vec;
  logic [1:0]  ack_dly;
  logic [7:0]  rdq[$];
  logic [15:0] expq[$];
  int          mismatches, checks_done, i, j;
  // Vectors in polling order
  logic [15:0] vec_tab [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                                16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  tlvic_top u_tlvic_top (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata),
    .supply_monitor_irq_request_i(flags[0]), .watchdog_irq_request_i(flags[1]),
    .pin_irq0_request_i(flags[2]), .converter_irq_request_i(flags[3]),
    .timer0_irq_request_i(flags[4]), .pin_irq1_request_i(flags[5]),
    .timer1_irq_request_i(flags[6]), .serial_sync_irq_request_i(flags[7]),
    .uart_rxtx_irq_request_i(flags[8]), .timer2_irq_request_i(flags[9]),
    .interval_counter_irq_request_i(flags[10]),
    .core_ack_i(ack), .core_reti_i(core_reti), .core_irq_req_o(req), .core_vector_o(vec),
    .core_push_pc_o(push), .core_load_pc_o(load), .src_taken_o(taken), .irq_o(irq)
  );

  tlvic_core_model u_tlvic_core_model (
    .clk_i(clk_sys_i), .rst_n_i(reset_n_i), .irq_req_i(req), .vector_i(vec),
    .load_i(load), .ack_dly_i(ack_dly), .ack_o(ack), .served_o(served),
    .served_vec_o(served_vec)
  );

  // ==========================================================================
  // Peripheral flags: held until the controller reports the source taken or clr_m clears them
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) flags <= 11'h000;
    else flags <= (flags | set_m) & ~clr_m & ~taken;
  end

  // ==========================================================================
  // Tasks
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr    <= 1'b0;
    // Idle edge so a following strobe is never assigned in the same step
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd   <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic flag(input logic [10:0] s, input logic [10:0] c);
    set_m <= s;
    clr_m <= c;
    @(posedge clk_sys_i);
    set_m <= 11'h000;
    clr_m <= 11'h000;
  endtask

  task automatic reti;
    core_reti <= 1'b1;
    @(posedge clk_sys_i);
    core_reti <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Request line must stay low for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      cmp("irq_req", 16'h0000, {15'h0000, req});
    end
  endtask

  // Bounded wait for one served vector; random core latency each time
  task automatic wait_served;
    int n;
    n = 0;
    ack_dly <= 2'($urandom_range(3, 0));
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (served !== 1'b1 && n < 60);
    if (n >= 60) begin
      mismatches++;
      $display("[FAIL] served expected 1 seen 0");
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Result watcher: oldest note against what appears
  always @(posedge clk_sys_i) begin
    rd_d   <= reg_rd;
    push_d <= push;
    if (rd_d) cmp("reg_rdata", {8'h00, rdq.pop_front()}, {8'h00, reg_rdata});
    if (served) cmp("vector", expq.pop_front(), served_vec);
    if (load) cmp("push_before_load", 16'h0001, {15'h0000, push_d});
    // Taken source must be the one whose vector is expected next
    if (push) begin
      exp_taken = 11'h000;
      for (j = 0; j < 11; j++) if (expq.size() > 0 && vec_tab[j] == expq[0]) exp_taken[j] = 1'b1;
      cmp("src_taken", {5'h00, exp_taken}, {5'h00, taken});
    end
  end

  initial begin
    repeat (3000) @(posedge clk_sys_i);
    mismatches++;
    $display("[FAIL] run expected finish seen timeout");
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    reset_n_i = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    core_reti = 1'b0; set_m = 11'h000; clr_m = 11'h000; ack_dly = 2'h0; rd_d = 1'b0;
    push_d = 1'b0; mismatches = 0; checks_done = 0;
    void'($urandom(85997));
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(tlvic_pkg::ADDR_IEN_PRI, 8'h00);
    rd(tlvic_pkg::ADDR_IEN_SEC, 8'ha0);
    rd(tlvic_pkg::ADDR_IPR_PRI, 8'h00);
    rd(8'h5a, 8'h00);
    wr(tlvic_pkg::ADDR_IPR_PRI, 8'hff);
    rd(tlvic_pkg::ADDR_IPR_PRI, 8'h7f);
    // Global gate closed, random individual enables
    wr(tlvic_pkg::ADDR_IEN_PRI, 8'h7f & 8'($urandom));
    flag(11'h7ff, 11'h000);
    quiet(8);
    flag(11'h000, 11'h7ff);
    wr(tlvic_pkg::ADDR_IEN_PRI, 8'h81);
    rd(tlvic_pkg::ADDR_IEN_PRI, 8'h81);
    expq.push_back(16'h0003);
    flag(11'h004, 11'h000);
    wait_served();
    reti();
    // Every source pending at once, all low except the watchdog
    wr(tlvic_pkg::ADDR_IPR_PRI, 8'h00);
    wr(tlvic_pkg::ADDR_IEN_PRI, 8'hff);
    wr(tlvic_pkg::ADDR_IEN_SEC, 8'h07);
    rd(tlvic_pkg::ADDR_IEN_SEC, 8'h87);
    expq.push_back(vec_tab[1]);
    for (i = 0; i < 11; i++) if (i != 1) expq.push_back(vec_tab[i]);
    flag(11'h7ff, 11'h000);
    repeat (11) begin
      wait_served();
      reti();
    end
    @(posedge clk_sys_i);
    cmp("irq_masked", 16'h0000, {15'h0000, irq});
    rd(tlvic_pkg::ADDR_STATUS, 8'h03);
    rd(tlvic_pkg::ADDR_STATUS, 8'h00);
    // Nesting: timer 0 high, pins low
    wr(tlvic_pkg::ADDR_MASK, 8'h0f);
    wr(tlvic_pkg::ADDR_IPR_PRI, 8'h02);
    wr(tlvic_pkg::ADDR_IEN_PRI, 8'h87);
    expq.push_back(16'h0003);
    flag(11'h004, 11'h000);
    wait_served();
    @(posedge clk_sys_i);
    cmp("irq", 16'h0001, {15'h0000, irq});
    rd(tlvic_pkg::ADDR_LEVEL, 8'h42);
    flag(11'h020, 11'h000);
    quiet(8);
    expq.push_back(16'h000b);
    flag(11'h010, 11'h000);
    wait_served();
    reti();
    quiet(6);
    expq.push_back(16'h0013);
    reti();
    wait_served();
    reti();
    reti();
    rd(tlvic_pkg::ADDR_STATUS, 8'h0f);
    repeat (3) @(posedge clk_sys_i);
    cmp("irq_cleared", 16'h0000, {15'h0000, irq});
    wrap_up();
  end
endmodule

`default_nettype wire
